// ==== logic/halt_pkg.sv ====
package halt_pkg;

    // ------------------------------------------------------------
    // clock and counter sizing
    // ------------------------------------------------------------
    localparam int          CLK_PERIOD_NS = 40;         // 25 MHz system clock
    localparam int          CNT_W         = 15;

    // ------------------------------------------------------------
    // option byte read stall after reset, in ns as printed
    // ------------------------------------------------------------
    localparam int          OPT_INT_MIN_NS  = 277000;   // internal or external input clock
    localparam int          OPT_INT_MAX_NS  = 1075000;
    localparam int          OPT_XTAL_MIN_NS = 276000;   // crystal or ceramic clock
    localparam int          OPT_XTAL_MAX_NS = 1074000;
    // least times round up, longest times round down
    localparam int          OPT_INT_MIN_CYC  = (OPT_INT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          OPT_INT_MAX_CYC  = OPT_INT_MAX_NS / CLK_PERIOD_NS;
    localparam int          OPT_XTAL_MIN_CYC = (OPT_XTAL_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          OPT_XTAL_MAX_CYC = OPT_XTAL_MAX_NS / CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // wait after an interrupt release, in clocks (11..13 and 3..5 allowed)
    // ------------------------------------------------------------
    localparam logic [14:0] WAKE_VEC_CYC  = 15'h000c;   // 12 clocks, vectored servicing
    localparam logic [14:0] WAKE_NEXT_CYC = 15'h0004;   // 4 clocks, next instruction

    // ------------------------------------------------------------
    // peripheral enable vector layout
    // ------------------------------------------------------------
    localparam int          PERIPH_N      = 6;
    localparam int          P_TIMER16     = 0;
    localparam int          P_TIMER8      = 1;
    localparam int          P_CONVERTER   = 2;
    localparam int          P_SERIAL      = 3;
    localparam int          P_VOLT_DET    = 4;
    localparam int          P_EXT_INT     = 5;
    localparam int          IRQ_N         = 8;

    // ------------------------------------------------------------
    // sequencer states
    // ------------------------------------------------------------
    typedef enum logic [4:0] {
        ST_BOOT     = 5'b00001,
        ST_OPT_WAIT = 5'b00010,
        ST_RUN      = 5'b00100,
        ST_HALT     = 5'b01000,
        ST_WAKE     = 5'b10000
    } state_e;

endpackage

// ==== logic/wait_counter.sv ====
`timescale 1ns/1ps
// down counter; expire marks the last cycle of a loaded wait
module wait_counter (
    // clock and reset
    input  wire logic                      clock,
    input  wire logic                      rst,
    // load side
    input  wire logic                      load,
    input  wire logic [halt_pkg::CNT_W-1:0] load_value,
    // status
    output logic      [halt_pkg::CNT_W-1:0] count,
    output logic                           expire
);

    logic [halt_pkg::CNT_W-1:0] count_r;

    // ------------------------------------------------------------
    // count down to zero, then rest
    // ------------------------------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            count_r <= '0;
        end else if (load) begin
            count_r <= load_value;
        end else if (count_r != '0) begin
            count_r <= count_r - 1'b1;
        end
    end

    assign count  = count_r;
    assign expire = (count_r == {{(halt_pkg::CNT_W-1){1'b0}}, 1'b1});

endmodule

// ==== logic/halt_standby_control.sv ====
`timescale 1ns/1ps
// Notes on behaviour
// RULE_01: executing the halt instruction puts the device into halt standby.
// RULE_02: an unmasked request already pending at halt entry makes standby end at once.
// RULE_03: in halt the processor clock is cut while the system oscillator keeps running.
// RULE_04: port output latches keep their pre-halt value throughout halt.
// RULE_05: timers, converter, serial port, voltage detector and external interrupts run in halt.
// RULE_06: the second 8-bit timer on the low-speed clock runs in halt unless that osc is stopped.
// RULE_07: a watchdog on the system clock stops in halt; software must not pick that clock (flagged only while the low-speed osc cannot be stopped)
// RULE_08: a watchdog on the low-speed clock counts in halt only while that oscillator runs.
// RULE_09: an unmasked request releases halt and, with acceptance enabled, is vectored.
// RULE_10: with acceptance disabled the release resumes at the next instruction instead.
// RULE_11: the release wait lasts 11 to 13 clocks when vectored and 3 to 5 when not.
// RULE_12: reset releases halt and restarts from the reset vector like any reset.
// RULE_13: with an internal or external input clock, reset stalls 277 us to 1.075 ms.
// RULE_14: with a crystal or ceramic clock, reset stalls 276 us to 1.074 ms.
// RULE_15: the low-speed oscillator stops by its stop bit only when the option allows it.
// RULE_16: a request whose mask flag is set never releases halt.
module halt_standby_control #(
    parameter int OPT_INT_CYC  = halt_pkg::OPT_INT_MIN_CYC,
    parameter int OPT_XTAL_CYC = halt_pkg::OPT_XTAL_MIN_CYC
) (
    // clock and reset
    input  wire logic                          clock,
    input  wire logic                          rst,
    // processor side
    input  wire logic                          halt_exec,
    output logic                               cpu_clock_enable,
    output logic                               reset_vector_start,
    output logic                               vector_service,
    output logic                               resume_next,
    output logic                               halted,
    output logic                               port_latch_write_enable,
    // interrupt flag and mask logic
    input  wire logic [halt_pkg::IRQ_N-1:0]    irq_request_flag,
    input  wire logic [halt_pkg::IRQ_N-1:0]    interrupt_mask_flag,
    input  wire logic                          interrupt_accept_enable,
    // option byte straps, caught after reset
    input  wire logic                          xtal_clock_opt,
    input  wire logic                          low_speed_osc_stoppable_opt,
    // clock configuration
    input  wire logic                          low_speed_osc_stop_bit,
    input  wire logic                          wdt_low_speed_sel,
    input  wire logic                          timer8b_low_speed_sel,
    // clock gating
    output logic                               sys_osc_enable,
    output logic                               low_speed_osc_run,
    output logic [halt_pkg::PERIPH_N-1:0]      periph_clock_enable,
    output logic                               timer8b_clock_enable,
    output logic                               wdt_clock_enable,
    output logic                               wdt_config_error,
    output logic                               por_enable
);

    // ------------------------------------------------------------
    // state and option registers
    // ------------------------------------------------------------
    halt_pkg::state_e                  state_r;
    halt_pkg::state_e                  state_nxt;
    logic                              vec_r;
    logic                              vec_nxt;
    logic                              stoppable_r;
    logic                              xtal_r;
    logic                              sys_osc_r;
    logic [halt_pkg::CNT_W-1:0]        cnt_val;
    logic                              cnt_expire;
    logic                              cnt_load;
    logic [halt_pkg::CNT_W-1:0]        cnt_load_value;
    logic [halt_pkg::CNT_W-1:0]        opt_load;

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    wire boot_st  = (state_r == halt_pkg::ST_BOOT);
    wire opt_st   = (state_r == halt_pkg::ST_OPT_WAIT);
    wire run_st   = (state_r == halt_pkg::ST_RUN);
    wire halt_st  = (state_r == halt_pkg::ST_HALT);
    wire wake_st  = (state_r == halt_pkg::ST_WAKE);
    // masked requests drop out here, so they never wake the core
    wire pending  = |(irq_request_flag & ~interrupt_mask_flag);                 // RULE_16
    wire ls_stop  = stoppable_r & low_speed_osc_stop_bit;                       // RULE_15
    wire wake_in  = (run_st & halt_exec & pending) | (halt_st & pending);       // RULE_02

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        vec_nxt   = vec_r;
        unique case (state_r)
            halt_pkg::ST_BOOT: begin
                state_nxt = halt_pkg::ST_OPT_WAIT;
            end
            halt_pkg::ST_OPT_WAIT: begin
                if (cnt_expire) begin
                    state_nxt = halt_pkg::ST_RUN;       // RULE_12
                end
            end
            halt_pkg::ST_RUN: begin
                if (halt_exec) begin
                    state_nxt = pending ? halt_pkg::ST_WAKE : halt_pkg::ST_HALT;  // RULE_01
                    vec_nxt   = interrupt_accept_enable;
                end
            end
            halt_pkg::ST_HALT: begin
                if (pending) begin
                    state_nxt = halt_pkg::ST_WAKE;      // RULE_09
                    vec_nxt   = interrupt_accept_enable;
                end
            end
            halt_pkg::ST_WAKE: begin
                if (cnt_expire) begin
                    state_nxt = halt_pkg::ST_RUN;
                end
            end
            default: begin
                state_nxt = halt_pkg::ST_BOOT;
            end
        endcase
    end

    // ------------------------------------------------------------
    // state flops; reset always lands in boot, even from halt
    // ------------------------------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_r <= halt_pkg::ST_BOOT;                // RULE_12
            vec_r   <= 1'b0;
        end else begin
            state_r <= state_nxt;
            vec_r   <= vec_nxt;
        end
    end

    // ------------------------------------------------------------
    // straps caught on the first edge after release, not in reset
    // ------------------------------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            stoppable_r <= 1'b0;
            xtal_r      <= 1'b0;
            sys_osc_r   <= 1'b0;
        end else begin
            sys_osc_r <= 1'b1;
            if (boot_st) begin
                stoppable_r <= low_speed_osc_stoppable_opt;
                xtal_r      <= xtal_clock_opt;
            end
        end
    end

    // ------------------------------------------------------------
    // shared wait counter: option read stall and release wait
    // ------------------------------------------------------------
    assign opt_load = xtal_clock_opt ? halt_pkg::CNT_W'(OPT_XTAL_CYC)           // RULE_14
                                     : halt_pkg::CNT_W'(OPT_INT_CYC);           // RULE_13
    assign cnt_load = boot_st | wake_in;
    assign cnt_load_value = boot_st ? opt_load
                          : (interrupt_accept_enable ? halt_pkg::WAKE_VEC_CYC   // RULE_11
                                                     : halt_pkg::WAKE_NEXT_CYC);

    wait_counter u_wait (
        .clock      (clock),
        .rst        (rst),
        .load       (cnt_load),
        .load_value (cnt_load_value),
        .count      (cnt_val),
        .expire     (cnt_expire)
    );

    // ------------------------------------------------------------
    // processor side outputs
    // ------------------------------------------------------------
    assign cpu_clock_enable        = run_st;                                    // RULE_03
    assign halted                  = halt_st;
    assign port_latch_write_enable = run_st;                                    // RULE_04
    assign reset_vector_start      = opt_st & cnt_expire;                       // RULE_12
    assign vector_service          = wake_st & cnt_expire & vec_r;              // RULE_09
    assign resume_next             = wake_st & cnt_expire & ~vec_r;             // RULE_10

    // ------------------------------------------------------------
    // clock gating; oscillator off from reset until the first edge after release
    // ------------------------------------------------------------
    assign sys_osc_enable       = sys_osc_r;                                    // RULE_03
    assign low_speed_osc_run    = sys_osc_r & ~ls_stop;                         // RULE_15
    assign periph_clock_enable  = {halt_pkg::PERIPH_N{sys_osc_r}};              // RULE_05
    assign por_enable           = 1'b1;                                         // RULE_05
    assign timer8b_clock_enable = timer8b_low_speed_sel ? low_speed_osc_run     // RULE_06
                                                        : sys_osc_r;
    // system-clocked watchdog must freeze with the core during halt
    assign wdt_clock_enable     = wdt_low_speed_sel ? low_speed_osc_run         // RULE_08
                                                    : (sys_osc_r & ~halt_st);   // RULE_07
    // flags the prohibited pairing; hardware still gates as above
    assign wdt_config_error     = ~wdt_low_speed_sel & sys_osc_r & ~stoppable_r; // RULE_07

    // ------------------------------------------------------------
    // stall length helper, seen only by the checks below
    // ------------------------------------------------------------
    logic [halt_pkg::CNT_W-1:0] stall_cyc_r;
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            stall_cyc_r <= '0;
        end else if ((boot_st | opt_st) & (stall_cyc_r != '1)) begin
            stall_cyc_r <= stall_cyc_r + 1'b1;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    halt_entry_a: assert property (@(posedge clock) disable iff (rst) // RULE_01
        run_st && halt_exec && !pending |=> halt_st && !cpu_clock_enable)
        else $error("halt instruction did not enter halt");
    early_exit_a: assert property (@(posedge clock) disable iff (rst) // RULE_02
        run_st && halt_exec && pending |=> wake_st)
        else $error("pending request did not end halt at once");
    cpu_gate_a: assert property (@(posedge clock) disable iff (rst) // RULE_03
        halt_st |-> !cpu_clock_enable && sys_osc_enable)
        else $error("cpu clock or oscillator wrong in halt");
    latch_hold_a: assert property (@(posedge clock) disable iff (rst) // RULE_04
        (halt_st || wake_st) |-> !port_latch_write_enable)
        else $error("port latch writable during halt");
    periph_run_a: assert property (@(posedge clock) disable iff (rst) // RULE_05
        halt_st |-> (&periph_clock_enable) && por_enable)
        else $error("peripheral gated in halt");
    timer_ls_a: assert property (@(posedge clock) disable iff (rst) // RULE_06
        halt_st && timer8b_low_speed_sel |-> timer8b_clock_enable == !ls_stop)
        else $error("low-speed timer gating wrong in halt");
    wdt_sys_a: assert property (@(posedge clock) disable iff (rst) // RULE_07
        halt_st && !wdt_low_speed_sel |-> !wdt_clock_enable)
        else $error("system-clocked watchdog ran in halt");
    wdt_ls_a: assert property (@(posedge clock) disable iff (rst) // RULE_08
        halt_st && wdt_low_speed_sel |-> wdt_clock_enable == !ls_stop)
        else $error("low-speed watchdog gating wrong");
    masked_hold_a: assert property (@(posedge clock) disable iff (rst) // RULE_16
        halt_st && !pending |=> halt_st)
        else $error("masked request released halt");
    wake_vec_a: assert property (@(posedge clock) disable iff (rst) // RULE_11
        $rose(wake_st) && vec_r |-> ##11 (wake_st && vector_service) ##1 run_st)
        else $error("vectored release wait not 12 clocks");
    wake_next_a: assert property (@(posedge clock) disable iff (rst) // RULE_10
        $rose(wake_st) && !vec_r |-> ##3 (wake_st && resume_next) ##1 run_st)
        else $error("plain release wait not 4 clocks");
    // stall follows the strap caught in boot, so shortened sim figures hold too
    stall_len_a: assert property (@(posedge clock) disable iff (rst) // RULE_13
        opt_st && cnt_expire |-> stall_cyc_r == (xtal_r ? halt_pkg::CNT_W'(OPT_XTAL_CYC)  // RULE_14
                                                        : halt_pkg::CNT_W'(OPT_INT_CYC)))
        else $error("option read stall length wrong");

endmodule

// ==== tb/core_irq_model.sv ====
`timescale 1ns/1ps
// ------------------------------------------------------------
// core and interrupt flag model facing the halt sequencer
// ------------------------------------------------------------
module core_irq_model (
    // clock and reset
    input  wire logic                       clock,
    input  wire logic                       rst,
    // from the sequencer and mask logic
    input  wire logic                       cpu_clock_enable,
    input  wire logic                       vector_service,
    input  wire logic [halt_pkg::IRQ_N-1:0] interrupt_mask_flag,
    // to the sequencer
    output logic                            halt_exec,
    output logic      [halt_pkg::IRQ_N-1:0] irq_request_flag
);
    initial begin
        halt_exec        = 1'b0;
        irq_request_flag = 8'h00;
    end

    // an acknowledged request drops its flag; masked ones stay pending
    always @(negedge clock) begin
        if (vector_service === 1'b1) begin
            irq_request_flag <= irq_request_flag & interrupt_mask_flag;
        end
    end

    // one halt instruction, held across one rising edge; a stopped core fetches nothing
    task automatic do_halt();
        @(negedge clock);
        halt_exec = cpu_clock_enable;
        @(negedge clock);
        halt_exec = 1'b0;
    endtask

    // raise or drop request flags off the sampling edge
    task automatic raise(input int idx);
        @(negedge clock);
        irq_request_flag[idx] = 1'b1;
    endtask

    task automatic clear_flags();
        @(negedge clock);
        irq_request_flag = 8'h00;
    endtask
endmodule

// ==== tb/halt_standby_control_tb.sv ====
`timescale 1ns/1ps
`define CHK(got, exp, msg) begin checked++; if ((got) !== (exp)) begin miscompares++; \
    $display("CHECK FAILED t=%0t %s", $time, msg); end end
module halt_standby_control_tb;
    // short stalls keep the run brief; expectations derive from these
    localparam int IN_CYC = 20;
    localparam int XT_CYC = 30;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic clock = 1'b0, rst = 1'b1, rv_seen = 1'b0;
    logic halt_exec, cpu_clock_enable, reset_vector_start, vector_service, resume_next, halted;
    logic port_latch_write_enable, interrupt_accept_enable = 1'b0, xtal_clock_opt = 1'b0;
    logic [halt_pkg::IRQ_N-1:0] irq_request_flag, interrupt_mask_flag = 8'hff;
    logic low_speed_osc_stoppable_opt = 1'b0, low_speed_osc_stop_bit = 1'b0;
    logic wdt_low_speed_sel = 1'b0, timer8b_low_speed_sel = 1'b0;
    logic sys_osc_enable, low_speed_osc_run, timer8b_clock_enable, wdt_clock_enable;
    logic wdt_config_error, por_enable;
    logic [halt_pkg::PERIPH_N-1:0] periph_clock_enable;
    int   checked = 0, miscompares = 0;

    always #(halt_pkg::CLK_PERIOD_NS / 2) clock = ~clock;

    halt_standby_control #(.OPT_INT_CYC(IN_CYC), .OPT_XTAL_CYC(XT_CYC)) dut (
        .clock(clock), .rst(rst), .halt_exec(halt_exec), .cpu_clock_enable(cpu_clock_enable),
        .reset_vector_start(reset_vector_start), .vector_service(vector_service),
        .resume_next(resume_next), .halted(halted),
        .port_latch_write_enable(port_latch_write_enable),
        .irq_request_flag(irq_request_flag), .interrupt_mask_flag(interrupt_mask_flag),
        .interrupt_accept_enable(interrupt_accept_enable), .xtal_clock_opt(xtal_clock_opt),
        .low_speed_osc_stoppable_opt(low_speed_osc_stoppable_opt),
        .low_speed_osc_stop_bit(low_speed_osc_stop_bit), .wdt_low_speed_sel(wdt_low_speed_sel),
        .timer8b_low_speed_sel(timer8b_low_speed_sel), .sys_osc_enable(sys_osc_enable),
        .low_speed_osc_run(low_speed_osc_run), .periph_clock_enable(periph_clock_enable),
        .timer8b_clock_enable(timer8b_clock_enable), .wdt_clock_enable(wdt_clock_enable),
        .wdt_config_error(wdt_config_error), .por_enable(por_enable));

    core_irq_model core (
        .clock(clock), .rst(rst), .cpu_clock_enable(cpu_clock_enable),
        .vector_service(vector_service), .interrupt_mask_flag(interrupt_mask_flag),
        .halt_exec(halt_exec), .irq_request_flag(irq_request_flag));

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic finish_test();
        $display("checked=%0d miscompares=%0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // counts falling edges until the chosen output is seen; bounded so a hang ends the run
    task automatic wait_sig(input int sel, input int limit, output int n);
        logic s;
        n = 0;
        rv_seen = 1'b0;
        do begin
            @(negedge clock);
            n++;
            rv_seen |= (reset_vector_start === 1'b1);
            case (sel)
                0: s = cpu_clock_enable;
                1: s = vector_service;
                default: s = resume_next;
            endcase
        end while (s !== 1'b1 && n < limit);
        if (s !== 1'b1) begin
            miscompares++;
            $display("CHECK FAILED t=%0t wait ran out", $time);
            finish_test();
        end
    endtask

    // straps are caught on the first edge after release, so set them under reset
    task automatic do_reset(input logic xtal, input logic stoppable);
        int n;
        @(negedge clock);
        rst = 1'b1;
        xtal_clock_opt = xtal;
        low_speed_osc_stoppable_opt = stoppable;
        repeat (6) @(negedge clock);
        `CHK(halted, 1'b0, "halt held in reset")
        `CHK(cpu_clock_enable, 1'b0, "core clock in reset")
        `CHK(por_enable, 1'b1, "power-on-clear off")
        rst = 1'b0;
        wait_sig(0, 200, n);
        `CHK(rv_seen, 1'b1, "no reset vector start")
        if (xtal) `CHK(n inside {[XT_CYC:XT_CYC+2]}, 1'b1, "crystal stall")
        else `CHK(n inside {[IN_CYC:IN_CYC+2]}, 1'b1, "internal stall")
        $display("reset test done, stall %0d", n);
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_config();
        low_speed_osc_stop_bit = 1'b1;
        @(negedge clock);
        `CHK(low_speed_osc_run, 1'b1, "locked osc stopped")
        `CHK(wdt_config_error, 1'b1, "system clock watchdog not flagged")
        `CHK(wdt_clock_enable, 1'b1, "watchdog idle while running")
        wdt_low_speed_sel = 1'b1;
        low_speed_osc_stop_bit = 1'b0;
        @(negedge clock);
        `CHK(wdt_config_error, 1'b0, "low-speed watchdog flagged")
        wdt_low_speed_sel = 1'b0;
        $display("config test done");
    endtask

    // masked request holds halt, unmasking with acceptance gives vectored service
    task automatic t_halt_hold();
        int n;
        interrupt_accept_enable = 1'b1;
        core.raise(3);
        core.do_halt();
        `CHK(halted, 1'b1, "halt not entered")
        `CHK(cpu_clock_enable, 1'b0, "core clock runs in halt")
        `CHK(sys_osc_enable, 1'b1, "oscillator stopped")
        `CHK(port_latch_write_enable, 1'b0, "port latch writable")
        `CHK(periph_clock_enable, 6'h3f, "peripheral gated")
        `CHK(timer8b_clock_enable, 1'b1, "prescaled timer stopped")
        `CHK(wdt_clock_enable, 1'b0, "system watchdog runs in halt")
        repeat (20) @(negedge clock);
        `CHK(halted, 1'b1, "masked request released halt")
        interrupt_mask_flag = 8'hf7;
        wait_sig(1, 40, n);
        `CHK(n inside {[11:13]}, 1'b1, "vectored wait length")
        `CHK(resume_next, 1'b0, "next-address resume with acceptance")
        @(negedge clock);
        `CHK(cpu_clock_enable, 1'b1, "core not restarted")
        interrupt_mask_flag = 8'hff;
        $display("vectored release test done, wait %0d", n);
    endtask

    task automatic t_next();
        int n;
        interrupt_accept_enable = 1'b0;
        interrupt_mask_flag = 8'hdf;
        core.do_halt();
        `CHK(halted, 1'b1, "halt not entered")
        core.raise(5);
        wait_sig(2, 40, n);
        `CHK(n inside {[3:5]}, 1'b1, "plain wait length")
        `CHK(vector_service, 1'b0, "serviced with acceptance off")
        core.clear_flags();
        interrupt_mask_flag = 8'hff;
        $display("next-address release test done, wait %0d", n);
    endtask

    task automatic t_pending();
        int n;
        interrupt_mask_flag = 8'hfe;
        core.raise(0);
        core.do_halt();
        `CHK(halted, 1'b0, "halted with request pending")
        `CHK(cpu_clock_enable, 1'b0, "wake skipped")
        wait_sig(2, 40, n);
        `CHK(n + 1 inside {[3:5]}, 1'b1, "pending wake length")
        core.clear_flags();
        interrupt_mask_flag = 8'hff;
        $display("pending at entry test done");
    endtask

    // with stopping allowed, low-speed timer and watchdog in halt follow the stop bit
    task automatic t_low_speed();
        wdt_low_speed_sel = 1'b1;
        timer8b_low_speed_sel = 1'b1;
        core.do_halt();
        `CHK(wdt_clock_enable, 1'b1, "low-speed watchdog stopped")
        `CHK(timer8b_clock_enable, 1'b1, "low-speed timer stopped")
        low_speed_osc_stop_bit = 1'b1;
        @(negedge clock);
        `CHK(low_speed_osc_run, 1'b0, "stop bit ignored")
        `CHK(wdt_clock_enable, 1'b0, "watchdog runs without osc")
        `CHK(timer8b_clock_enable, 1'b0, "timer runs without osc")
        `CHK(halted, 1'b1, "halt lost")
        low_speed_osc_stop_bit = 1'b0;
        $display("low-speed test done");
        do_reset(1'b0, 1'b1);
    endtask

    initial begin
        do_reset(1'b0, 1'b0);
        t_config();
        // halt tests use the system-clocked watchdog, legal only with a stoppable osc
        do_reset(1'b1, 1'b1);
        t_halt_hold();
        t_next();
        t_pending();
        t_low_speed();
        finish_test();
    end
endmodule
